// ===== verilog/cell_monitor_conv_sequencer.sv
// conversion sequencer: start detection, mux stepping, acquisition, averaging, results
// assumes an analog front end giving a comparator answer against o_dac_code
`timescale 1ns/10ps
`include "cell_seq_defines.svh"
module cell_monitor_conv_sequencer
  import cell_seq_pkg::*;
#(
  parameter int BITS = 12
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_conv_start_n,
  input  wire logic             i_spi_cs_n,
  input  wire logic [15:0]      i_ctrl,
  input  wire logic             i_ctrl_wr,
  input  wire logic             i_src_is_spi,
  input  wire logic             i_cmp_above,
  input  wire logic [3:0]       i_rd_ch,
  output logic      [3:0]       o_mux_sel,
  output logic                  o_mux_temp,
  output logic                  o_hold,
  output logic      [BITS-1:0]  o_dac_code,
  output logic                  o_busy,
  output logic                  o_seq_done,
  output logic      [BITS-1:0]  o_rd_data,
  output logic      [15:0]      o_ctrl
);
  logic [15:0]      ctrl_r;
  logic             src_spi_r;
  logic [1:0]       cnv_sync_r;
  logic [1:0]       cs_sync_r;
  logic             cnv_prev_r;
  logic             cs_prev_r;
  seq_state_t       state_r;
  logic [3:0]       ch_r;
  logic [3:0]       avg_cnt_r;
  logic [BITS+2:0]  acc_r;
  logic [4:0]       tmr_r;
  logic [BITS-1:0]  result_r [`NUM_CH];
  logic             sar_start;
  logic             sar_done;
  logic [BITS-1:0]  sar_code;
  logic [BITS-1:0]  sar_trial;

  wire [1:0] seq_sel  = ctrl_r[`SEQ_SEL_HI:`SEQ_SEL_LO];
  wire [1:0] avg_sel  = ctrl_r[`AVG_HI:`AVG_LO];
  wire [1:0] acq_sel  = ctrl_r[`ACQ_LO+1:`ACQ_LO];
  // averaging count 1, 2, 4 or 8
  wire [3:0] avg_num  = 4'h1 << avg_sel;
  // acquisition 400 ns per step
  wire [4:0] acq_cyc  = 5'((32'(acq_sel) + 32'd1) * `ACQ_STEP_CYC);
  wire       pin_fall = cnv_prev_r & ~cnv_sync_r[1];
  wire       cs_rise  = ~cs_prev_r & cs_sync_r[1];
  wire       trig     = src_spi_r ? cs_rise : pin_fall;
  wire       is_temp  = ch_r >= 4'(`NUM_CELLS);
  wire       self_tst = seq_sel == 2'(seq_self_test);
  // channel after ch_r given the selected set, all ones when done
  wire [3:0] nxt_ch =
      self_tst                               ? 4'hf :
      (ch_r < 4'(`NUM_CELLS - 1))            ? ch_r + 4'h1 :
      (seq_sel == 2'(seq_volts_only))        ? 4'hf :
      (seq_sel == 2'(seq_odd_temps))         ? ((ch_r == 4'h5) ? 4'h6 :
                                                (ch_r < 4'ha) ? ch_r + 4'h2 : 4'hf) :
      (ch_r < 4'(`NUM_CH - 1))               ? ch_r + 4'h1 : 4'hf;
  wire [3:0] first_ch = self_tst ? `SELFTEST_CH : 4'h0;
  // average in straight binary, truncating
  wire [BITS+2:0] acc_sum = acc_r + (BITS+3)'(sar_code);
  // acc_r already holds the last code by the store cycle, so sar_code is not added again
  wire [BITS-1:0] avg_res = BITS'(acc_r >> avg_sel);

  assign sar_start  = state_r == st_acq && tmr_r == 5'd0;
  assign o_hold     = state_r == st_conv;
  assign o_mux_sel  = is_temp ? ch_r - 4'(`NUM_CELLS) : ch_r;
  // temp channels span 0-5 V, cell pairs 1-5 V in the front end
  assign o_mux_temp = is_temp;
  assign o_dac_code = sar_trial;
  assign o_busy     = state_r != st_idle;
  assign o_ctrl     = ctrl_r;

  sar_core #(.BITS(BITS)) u_sar (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_start     (sar_start),
    .i_cmp_above (i_cmp_above),
    .o_trial     (sar_trial),
    .o_code      (sar_code),
    .o_done      (sar_done)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnv_sync_r <= 2'h3;
      cs_sync_r  <= 2'h3;
      cnv_prev_r <= 1'b1;
      cs_prev_r  <= 1'b1;
    end else begin
      cnv_sync_r <= {cnv_sync_r[0], i_conv_start_n};
      cs_sync_r  <= {cs_sync_r[0], i_spi_cs_n};
      cnv_prev_r <= cnv_sync_r[1];
      cs_prev_r  <= cs_sync_r[1];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_r    <= `CTRL_RESET;
      src_spi_r <= 1'b0;
    end else if (i_ctrl_wr) begin
      ctrl_r    <= i_ctrl;
      src_spi_r <= i_src_is_spi;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_r    <= st_idle;
      ch_r       <= 4'h0;
      avg_cnt_r  <= 4'h0;
      acc_r      <= '0;
      tmr_r      <= 5'd0;
      o_seq_done <= 1'b0;
    end else begin
      o_seq_done <= 1'b0;
      case (state_r)
        st_idle: begin
          // first cell already tracking, so the edge holds at once
          if (trig) begin
            state_r   <= st_acq;
            ch_r      <= first_ch;
            tmr_r     <= 5'd0;
            avg_cnt_r <= 4'h0;
            acc_r     <= '0;
          end
        end
        st_acq: begin
          // a new start here or later is ignored
          if (tmr_r == 5'd0) begin
            state_r <= st_conv;
          end else begin
            tmr_r <= tmr_r - 5'd1;
          end
        end
        st_conv: begin
          if (sar_done) begin
            acc_r     <= acc_sum;
            avg_cnt_r <= avg_cnt_r + 4'h1;
            state_r   <= st_store;
          end
        end
        st_store: begin
          // next slot: acquisition sized so each slot stays above 1 us
          tmr_r <= acq_cyc - 5'd1;
          if (avg_cnt_r != avg_num) begin
            state_r <= st_acq;
          end else begin
            avg_cnt_r <= 4'h0;
            acc_r     <= '0;
            if (nxt_ch == 4'hf) begin
              ch_r       <= 4'h0;
              state_r    <= st_idle;
              o_seq_done <= 1'b1;
            end else begin
              ch_r    <= nxt_ch;
              state_r <= st_acq;
            end
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // one result register per cell and temp channel; the self-test channel has none
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : g_res
      always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
          result_r[g] <= '0;
        end else if (state_r == st_store && avg_cnt_r == avg_num
                     && ch_r == 4'(g)) begin
          result_r[g] <= avg_res;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= (i_rd_ch < 4'(`NUM_CH)) ? result_r[i_rd_ch] : '0;
    end
  end
endmodule // cell_monitor_conv_sequencer

// ===== verilog/cell_seq_defines.svh
// timing counts and field positions for the cell monitor conversion sequencer
// assumes a 10 MHz core clock
`ifndef CELL_SEQ_DEFINES_SVH
`define CELL_SEQ_DEFINES_SVH
`define CLK_PERIOD_NS     100
`define ACQ_STEP_NS       400
`define ACQ_STEP_CYC      ((`ACQ_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOT_MIN_NS       1000
`define SLOT_MIN_CYC      ((`SLOT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEQ_SEL_HI        15
`define SEQ_SEL_LO        14
`define AVG_HI            10
`define AVG_LO            9
`define ACQ_HI            6
`define ACQ_LO            5
`define CTRL_RESET        16'h0000
`define NUM_CELLS         6
`define NUM_TEMPS         6
`define NUM_CH            12
`define SELFTEST_CH       4'hc
`endif

// ===== verilog/cell_seq_pkg.sv
// types for the cell monitor conversion sequencer
// assumes cell_seq_defines.svh is compiled alongside
package cell_seq_pkg;
  typedef enum logic [1:0] {
    seq_all_t_sel, seq_odd_temps, seq_volts_only, seq_self_test
  } seq_sel_t;
  typedef enum logic [2:0] {
    st_idle, st_acq, st_conv, st_store
  } seq_state_t;
endpackage

// ===== verilog/sar_core.sv
// 12-bit successive approximation engine, one bit decided per clock
// assumes the comparator input settles within one core clock
`timescale 1ns/10ps
module sar_core #(
  parameter int BITS = 12
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_start,
  input  wire logic            i_cmp_above,
  output logic      [BITS-1:0] o_trial,
  output logic      [BITS-1:0] o_code,
  output logic                 o_done
);
  logic [BITS-1:0] trial_r;
  logic [BITS-1:0] mask_r;
  logic            busy_r;
  logic [BITS-1:0] kept;

  // keep the trial bit when the input sits at or above the trial level
  assign kept    = i_cmp_above ? trial_r : (trial_r & ~mask_r);
  assign o_trial = trial_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      trial_r <= '0;
      mask_r  <= '0;
      busy_r  <= 1'b0;
      o_code  <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy_r) begin
        mask_r  <= {1'b1, {(BITS-1){1'b0}}};
        trial_r <= {1'b1, {(BITS-1){1'b0}}};
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        mask_r  <= mask_r >> 1;
        trial_r <= kept | (mask_r >> 1);
        if (mask_r[0]) begin
          busy_r <= 1'b0;
          o_code <= kept;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule // sar_core

// ===== sim/conv_seq_monitor.sv
// port checker for the conversion sequencer
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/10ps
module conv_seq_monitor #(
  parameter int BITS = 12
) (
  input logic            i_core_clk,
  input logic            i_rst_n,
  input logic            i_conv_start_n,
  input logic            i_spi_cs_n,
  input logic [15:0]     i_ctrl,
  input logic            i_ctrl_wr,
  input logic [3:0]      i_rd_ch,
  input logic [3:0]      o_mux_sel,
  input logic            o_mux_temp,
  input logic            o_hold,
  input logic            o_busy,
  input logic            o_seq_done,
  input logic [BITS-1:0] o_rd_data,
  input logic [15:0]     o_ctrl
);
  logic [2:0] age_r;
  logic       pin_r;
  logic       cs_r;
  // cycles since either start line last moved
  always_ff @(posedge i_core_clk) begin
    pin_r <= i_conv_start_n;
    cs_r  <= i_spi_cs_n;
    if (!i_rst_n) age_r <= 3'h7;
    else if (pin_r != i_conv_start_n || cs_r != i_spi_cs_n) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_hold_13;
    o_hold [*8] ##1 o_hold [*5] ##1 !o_hold;
  endsequence
  sequence s_track_4;
    !o_hold [*4];
  endsequence
  a_hold_in_busy: assert property (o_hold |-> o_busy)
    else $error("hold outside a sequence");
  a_hold_length: assert property ($rose(o_hold) |-> s_hold_13)
    else $error("hold length wrong");
  a_track_time: assert property ($fell(o_hold) |-> s_track_4)
    else $error("acquisition too short");
  a_done_pulse: assert property (o_seq_done |=> !o_seq_done)
    else $error("done longer than one cycle");
  a_mux_home: assert property (!o_busy |-> o_mux_sel == 4'h0 && !o_mux_temp)
    else $error("mux not on first cell when idle");
  a_busy_cause: assert property ($rose(o_busy) |-> age_r < 3'h7)
    else $error("sequence began without a start edge");
  a_ctrl_load: assert property (i_ctrl_wr |=> o_ctrl == $past(i_ctrl))
    else $error("control word not loaded");
  a_rd_refuse: assert property (i_rd_ch > 4'hb |=> o_rd_data == '0)
    else $error("unused channel read not zero");
endmodule // conv_seq_monitor
bind cell_monitor_conv_sequencer conv_seq_monitor #(.BITS(BITS)) u_conv_seq_monitor (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_conv_start_n(i_conv_start_n),
  .i_spi_cs_n(i_spi_cs_n), .i_ctrl(i_ctrl), .i_ctrl_wr(i_ctrl_wr), .i_rd_ch(i_rd_ch),
  .o_mux_sel(o_mux_sel), .o_mux_temp(o_mux_temp), .o_hold(o_hold), .o_busy(o_busy),
  .o_seq_done(o_seq_done), .o_rd_data(o_rd_data), .o_ctrl(o_ctrl));

// ===== sim/host_model.sv
// host and analog front end: start pulses and a fixed level per channel
// assumes the bench calls start_pulse from its main process
`timescale 1ns/10ps
module host_model (
  input  logic        i_core_clk,
  input  logic [3:0]  i_mux_sel,
  input  logic        i_mux_temp,
  input  logic [11:0] i_dac_code,
  input  logic [11:0] i_base,
  output logic        o_conv_start_n,
  output logic        o_spi_cs_n,
  output logic        o_cmp_above
);
  wire [3:0]  ch    = i_mux_temp ? i_mux_sel + 4'h6 : i_mux_sel;
  wire [11:0] level = i_base + 12'h155 * {8'h00, ch};
  assign o_cmp_above = level >= i_dac_code;
  initial begin
    o_conv_start_n = 1'b1;
    o_spi_cs_n     = 1'b1;
  end
  task start_pulse(input logic spi);
    @(negedge i_core_clk);
    if (spi) o_spi_cs_n = 1'b0;
    else o_conv_start_n = 1'b0;
    repeat (3) @(negedge i_core_clk);
    o_spi_cs_n     = 1'b1;
    o_conv_start_n = 1'b1;
  endtask
endmodule // host_model

// ===== sim/cell_monitor_conv_sequencer_tb.sv
// self-checking bench for the conversion sequencer
// assumes host_model and conv_seq_monitor are compiled alongside
`timescale 1ns/10ps
module cell_monitor_conv_sequencer_tb;
  logic        clk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, src = 1'b0, rd_v = 1'b0;
  logic        rd_q = 1'b0, chk = 1'b0, pin_n, cs_n, cmp, mux_temp, hold, busy, done;
  logic [15:0] ctrl = 16'h0000, o_ctrl;
  logic [3:0]  rd_ch = 4'h0, mux_sel;
  logic [11:0] base = 12'h000, dac, rd_data;
  logic [11:0] exp_r [12];
  logic [11:0] rq [$];
  logic [4:0]  chq [$];
  int          mismatches = 0, num_checks = 0, seed = 53528, busy_cyc, cyc = 0, d0;
  always #50 clk = ~clk;
  cell_monitor_conv_sequencer u_cell_monitor_conv_sequencer (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_conv_start_n(pin_n), .i_spi_cs_n(cs_n), .i_ctrl(ctrl),
    .i_ctrl_wr(ctrl_wr), .i_src_is_spi(src), .i_cmp_above(cmp), .i_rd_ch(rd_ch),
    .o_mux_sel(mux_sel), .o_mux_temp(mux_temp), .o_hold(hold), .o_dac_code(dac),
    .o_busy(busy), .o_seq_done(done), .o_rd_data(rd_data), .o_ctrl(o_ctrl));
  host_model u_host_model (.i_core_clk(clk), .i_mux_sel(mux_sel), .i_mux_temp(mux_temp),
    .i_dac_code(dac), .i_base(base), .o_conv_start_n(pin_n), .o_spi_cs_n(cs_n),
    .o_cmp_above(cmp));
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input string what, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (e !== s) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (busy === 1'b1) busy_cyc++;
    if (rd_q) check("result", {4'h0, rq.pop_front()}, {4'h0, rd_data});
    rd_q <= rd_v;
    if (chk && $rose(hold))
      check("channel", {11'h0, chq.pop_front()}, {11'h0, mux_temp, mux_sel});
    if (cyc > 60000) begin
      mismatches++;
      end_of_test;
    end
  end
  task set_ctrl(input logic [15:0] c, input logic s);
    @(negedge clk);
    ctrl = c | (16'($random(seed)) & 16'h399f);
    src = s;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
  endtask
  task run_seq(input logic [1:0] sq, input logic spi, input logic again);
    int n;
    busy_cyc = 0;
    chk = (sq != 2'b11);
    for (int i = 0; i < 12; i++)
      if (chk && (i < 6 || sq == 2'b00 || (sq == 2'b01 && i[0] == 1'b0))) begin
        // one hold per averaged conversion, so one note for each
        for (int k = 0; k < (1 << ctrl[10:9]); k++)
          chq.push_back(i < 6 ? {1'b0, i[3:0]} : {1'b1, i[3:0] - 4'h6});
        exp_r[i] = base + 12'h155 * i[11:0];
      end
    u_host_model.start_pulse(spi);
    if (again) u_host_model.start_pulse(spi);
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("done", 16'h1, {15'h0, done});
    chk = 1'b0;
    repeat (2) @(negedge clk);
    check("mux home", 16'h0, {11'h0, mux_temp, mux_sel});
    for (int c = 0; c < 13; c++) begin
      @(negedge clk);
      rd_ch = c[3:0];
      rd_v = 1'b1;
      rq.push_back(c < 12 ? exp_r[c] : 12'h000);
    end
    @(negedge clk);
    rd_v = 1'b0;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check("ctrl reset", 16'h0000, o_ctrl);
    base = 12'($random(seed));
    run_seq(2'b00, 1'b0, 1'b1);
    check("slot time", 16'h1, {15'h0, busy_cyc >= 120});
    for (int a = 0; a < 4; a++) begin
      base = 12'($random(seed));
      set_ctrl(16'h8000 | 16'(a << 5), 1'b0);
      run_seq(2'b10, 1'b0, 1'b0);
      if (a == 0) d0 = busy_cyc;
      check("acq time", 16'(d0 + 20 * a), 16'(busy_cyc));
    end
    set_ctrl(16'h4000, 1'b1);
    u_host_model.start_pulse(1'b0);
    repeat (6) @(negedge clk);
    check("pin ignored", 16'h0, {15'h0, busy});
    run_seq(2'b01, 1'b1, 1'b0);
    set_ctrl(16'hc000, 1'b1);
    run_seq(2'b11, 1'b1, 1'b0);
    for (int v = 1; v < 4; v++) begin
      set_ctrl(16'h8000 | 16'(v << 9), 1'b0);
      run_seq(2'b10, 1'b0, 1'b0);
    end
    check("channel queue", 16'h0, 16'(chq.size()));
    end_of_test;
  end
endmodule // cell_monitor_conv_sequencer_tb
